// ===== fss_map.svh
// Constants for the frame synchronized pair scrambler.
// Assumes inclusion by bare name from the design files only.
`ifndef FSS_MAP_SVH
`define FSS_MAP_SVH

// Register width and seed; all ones is the frame start state
`define FSS_LFSR_WIDTH 8
`define FSS_LFSR_SEED 8'hff
// Galois taps: stage eight feeds stages three, four and five
`define FSS_TAP_MASK 8'h1c
// Stage positions, stage one at bit zero
`define FSS_STAGE_SIX 3'h5
`define FSS_STAGE_FIVE 3'h4
`define FSS_STAGE_LAST 3'h7
// Steps of the register per pair
`define FSS_STEPS_PER_PAIR 2
// Pairs in one full sequence period
`define FSS_SEQ_PAIRS 255

// Timing: chip period and pair cycle in picoseconds
`define FSS_CLK_PERIOD_PS 25000
`define FSS_CHIP_PERIOD_PS 41700
`define FSS_CHIPS_PER_PAIR 3
`define FSS_PAIR_PERIOD_PS (`FSS_CHIP_PERIOD_PS * `FSS_CHIPS_PER_PAIR)
// Longest time, rounded down to whole clocks
`define FSS_PAIR_CYCLES (`FSS_PAIR_PERIOD_PS / `FSS_CLK_PERIOD_PS)

// Buffer shape
`define FSS_FIFO_DEPTH 16
`define FSS_PAIR_WIDTH 2

`endif

// ===== fss_pkg.sv
// Types shared by the pair scrambler and its buffer.
// Assumes nothing of its surroundings.
package fss_pkg;

  typedef struct packed {
    logic first;
    logic second;
  } fss_pair_t;

  typedef enum logic {
    FSS_DIR_TX,
    FSS_DIR_RX
  } fss_dir_t;

  typedef enum {
    FSS_IDLE,
    FSS_RUN
  } fss_state_t;

endpackage

// ===== fss_scrambler.sv
// Frame synchronized pair scrambler / descrambler with its input buffer.
// Assumes one 40 MHz clock, synchronous active-low reset, a framing
// block that pulses frame start before each frame, and a coder on
// the far side that accepts one pair per pair cycle when ready.
`include "fss_map.svh"

////////////////////////////////////////////////////////////////////////
// Input buffer for bit pairs

module fss_fifo #(
  parameter int WIDTH = `FSS_PAIR_WIDTH,
  parameter int DEPTH = `FSS_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fss_fifo depth must be a power of two of at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("fss_fifo width must be at least 1");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  // Pointers wrap by width alone, hence the power-of-two depth
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic full_reg;
  logic empty_reg;
  logic space_reg;
  wire push = wr_valid_in && !full_reg;
  wire pop = rd_ready_in && !empty_reg;

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW + 1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || clear_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  // Flags are registered from the next count, so they match it
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || clear_in) begin
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
      space_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      full_reg <= (count_next == (AW + 1)'(DEPTH));
      empty_reg <= (count_next == '0);
      space_reg <= (count_next != (AW + 1)'(DEPTH));
    end
  end

  // Storage has no reset; contents are only read behind valid
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= wr_data_in;
    end
  end

  // Own flop: low through reset, no gate between flop and port
  assign wr_ready_out = space_reg;
  assign rd_valid_out = !empty_reg;
  assign rd_data_out = mem_reg[rd_ptr_reg];

endmodule

////////////////////////////////////////////////////////////////////////
// Scrambler / descrambler top

module fss_scrambler #(
  parameter int FIFO_DEPTH = `FSS_FIFO_DEPTH,
  parameter int PAIR_CYCLES = `FSS_PAIR_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire fss_pkg::fss_dir_t dir_in,
  input wire logic frame_start_in,
  input wire fss_pkg::fss_pair_t pair_in,
  input wire logic pair_valid_in,
  output logic pair_ready_out,
  output fss_pkg::fss_pair_t pair_out,
  output logic pair_valid_out,
  input wire logic pair_ready_in,
  output fss_pkg::fss_pair_t seq_pair_out,
  output logic stage_six_serial_out
);

  localparam int CW = (PAIR_CYCLES > 1) ? $clog2(PAIR_CYCLES) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(PAIR_CYCLES - 1);
  localparam int PW = $clog2(`FSS_SEQ_PAIRS);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(`FSS_SEQ_PAIRS - 1);

  ////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (PAIR_CYCLES < 1) begin : g_bad_cycles
    $error("fss_scrambler pair cycle must be at least one clock");
  end
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("fss_scrambler buffer depth must be at least 2");
  end
  if (`FSS_LFSR_SEED == 0) begin : g_bad_seed
    $error("fss_scrambler seed must not be all zeros");
  end
  if (`FSS_STAGE_SIX >= `FSS_LFSR_WIDTH || `FSS_STAGE_FIVE >= `FSS_LFSR_WIDTH) begin : g_bad_stage
    $error("fss_scrambler output stages lie outside the register");
  end
  if (`FSS_STEPS_PER_PAIR < 1) begin : g_bad_steps
    $error("fss_scrambler needs at least one step per pair");
  end

  ////////////////////////////////////////////////////////////////////
  // Register stepping

  // One Galois step: last stage shifts into stage one and is
  // folded into the tapped stages on the way up.
  function automatic logic [`FSS_LFSR_WIDTH-1:0] lfsr_step(
    input logic [`FSS_LFSR_WIDTH-1:0] cur
  );
    logic fb;
    logic [`FSS_LFSR_WIDTH-1:0] nxt;
    fb = cur[`FSS_STAGE_LAST];
    nxt = {cur[`FSS_LFSR_WIDTH-2:0], fb};
    nxt = nxt ^ ({`FSS_LFSR_WIDTH{fb}} & `FSS_TAP_MASK);
    return nxt;
  endfunction

  logic [`FSS_LFSR_WIDTH-1:0] lfsr_reg;
  logic [`FSS_LFSR_WIDTH-1:0] lfsr_next;
  logic [`FSS_LFSR_WIDTH-1:0] step_chain [`FSS_STEPS_PER_PAIR + 1];

  assign step_chain[0] = lfsr_reg;
  for (genvar i = 0; i < `FSS_STEPS_PER_PAIR; i++) begin : g_step
    assign step_chain[i + 1] = lfsr_step(step_chain[i]);
  end

  wire [`FSS_LFSR_WIDTH-1:0] lfsr_two = step_chain[`FSS_STEPS_PER_PAIR];
  // Guard against a corrupted register locking at zero
  wire lfsr_two_zero = (lfsr_two == '0);

  ////////////////////////////////////////////////////////////////////
  // Pair cycle pacing

  fss_pkg::fss_state_t state_reg;
  fss_pkg::fss_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  // No ticks before the first frame start, so reset alone sends nothing
  wire tick = (state_reg == fss_pkg::FSS_RUN) && (cnt_reg == CNT_LAST);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fss_pkg::FSS_IDLE: begin
        if (frame_start_in) begin
          state_next = fss_pkg::FSS_RUN;
        end
      end
      fss_pkg::FSS_RUN: begin
        state_next = fss_pkg::FSS_RUN;
      end
    endcase
  end

  // Counter free-runs in idle; frame start clears it before use
  assign cnt_next = (frame_start_in || tick) ? '0 : cnt_reg + CW'(1);

  ////////////////////////////////////////////////////////////////////
  // Buffer and data path

  fss_pkg::fss_pair_t fifo_pair;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_in_ready;

  fss_fifo #(
    .WIDTH(`FSS_PAIR_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(1'b0),
    .wr_data_in(pair_in),
    .wr_valid_in(pair_valid_in),
    .wr_ready_out(fifo_in_ready),
    .rd_data_out(fifo_pair),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready)
  );

  // A pair is consumed only when the coder side can take it
  assign fifo_ready = tick && pair_ready_in && !frame_start_in;
  wire take = fifo_ready && fifo_valid;

  ////////////////////////////////////////////////////////////////////
  // Period tracking

  // Pairs taken since frame start. A full period brings the state
  // back to the seed, so reloading there costs nothing and heals a
  // register upset in mid-frame.
  logic [PW-1:0] period_reg;
  logic [PW-1:0] period_next;
  wire period_end = (period_reg == PERIOD_LAST);
  wire [PW-1:0] period_inc = period_end ? '0 : period_reg + PW'(1);
  assign period_next = frame_start_in ? '0 : (take ? period_inc : period_reg);

  fss_pkg::fss_pair_t seq_pair;
  fss_pkg::fss_pair_t mixed_pair;
  assign seq_pair.first = lfsr_reg[`FSS_STAGE_SIX];
  assign seq_pair.second = lfsr_reg[`FSS_STAGE_FIVE];
  // Same XOR serves both directions; the select only labels the
  // pair as source data or decoded data.
  assign mixed_pair = fifo_pair ^ seq_pair;

  fss_pkg::fss_pair_t seq_next;
  assign seq_next.first = lfsr_next[`FSS_STAGE_SIX];
  assign seq_next.second = lfsr_next[`FSS_STAGE_FIVE];

  always_comb begin
    lfsr_next = lfsr_reg;
    if (frame_start_in) begin
      lfsr_next = `FSS_LFSR_SEED;
    end else if (take) begin
      lfsr_next = (lfsr_two_zero || period_end) ? `FSS_LFSR_SEED : lfsr_two;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg <= fss_pkg::FSS_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      lfsr_reg <= `FSS_LFSR_SEED;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      period_reg <= '0;
    end else begin
      period_reg <= period_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output registers

  // Data outputs change only with a taken pair
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pair_out <= '0;
      pair_valid_out <= 1'b0;
    end else begin
      pair_valid_out <= take;
      if (take) begin
        pair_out <= mixed_pair;
      end
    end
  end

  // Sequence outputs show the pair the next take will use
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      seq_pair_out <= '1;
      stage_six_serial_out <= 1'b1;
    end else begin
      seq_pair_out <= seq_next;
      stage_six_serial_out <= seq_next.first;
    end
  end

  // Ready is the buffer's own space flop; one more stage here would
  // claim room for a cycle after the buffer fills and lose a pair.
  assign pair_ready_out = fifo_in_ready;

  // Direction only steers which party feeds pair_in; unused here
  wire unused_dir = (dir_in == fss_pkg::FSS_DIR_RX);

endmodule

// ===== fsps_scrambler_props.sv
// Port checker for the pair scrambler.
// Assumes one clock domain and a bind onto the scrambler top.
module fsps_scrambler_props (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire fss_pkg::fss_dir_t dir_in,
  input wire logic frame_start_in,
  input wire fss_pkg::fss_pair_t pair_in,
  input wire logic pair_valid_in,
  input wire logic pair_ready_out,
  input wire fss_pkg::fss_pair_t pair_out,
  input wire logic pair_valid_out,
  input wire logic pair_ready_in,
  input wire fss_pkg::fss_pair_t seq_pair_out,
  input wire logic stage_six_serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  //////////////////////////////////////////////////////////////
  frame_seed_a: assert property (frame_start_in |=> seq_pair_out == 2'b11)
    else $error("sequence pair not ones after frame start");
  serial_tap_a: assert property (stage_six_serial_out == seq_pair_out.first)
    else $error("serial output differs from first sequence bit");
  step_on_take_a: assert property (!$stable(seq_pair_out) |-> pair_valid_out || $past(frame_start_in))
    else $error("sequence moved without a pair");
  pair_spacing_a: assert property (pair_valid_out |=> !pair_valid_out [*4])
    else $error("pairs closer than one pair cycle");
  start_gap_a: assert property (frame_start_in |=> !pair_valid_out [*5])
    else $error("pair too soon after frame start");
  ready_gate_a: assert property (pair_valid_out |-> $past(pair_ready_in))
    else $error("pair sent while sink not ready");
  hold_out_a: assert property (!pair_valid_out |-> $stable(pair_out))
    else $error("output pair moved without valid");
  first_pair_a: assert property (frame_start_in ##1 (!frame_start_in && !pair_valid_out) [*5]
    ##1 pair_valid_out |-> seq_pair_out == 2'b01)
    else $error("second sequence pair wrong");
  cover property (pair_valid_out);
  cover property (pair_valid_in && !pair_ready_out);
  cover property (frame_start_in ##6 pair_valid_out);
endmodule

bind fss_scrambler fsps_scrambler_props u_props (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .dir_in(dir_in), .frame_start_in(frame_start_in), .pair_in(pair_in),
  .pair_valid_in(pair_valid_in), .pair_ready_out(pair_ready_out), .pair_out(pair_out),
  .pair_valid_out(pair_valid_out), .pair_ready_in(pair_ready_in),
  .seq_pair_out(seq_pair_out), .stage_six_serial_out(stage_six_serial_out));

// ===== fsps_sink_model.sv
// Coder-side sink that takes pairs from the scrambler output.
// Assumes the bench holds stall_in high to test a full buffer.
module fsps_sink_model (
  input wire logic clk_in,
  input wire logic stall_in,
  output logic ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'hd521;
  initial ready_out = 1'b0;
  // Random gaps so ticks without a taker are exercised
  always @(posedge clk_in) ready_out <= !stall_in && ($random(seed) % 3 != 0);
endmodule

// ===== test_frame_sync_pair_scrambler.sv
// Self-checking bench for the pair scrambler.
// Assumes the sink model and the bound checker are compiled first.
module test_frame_sync_pair_scrambler;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_n_in, frame_start_in, pair_valid_in, stall;
  logic pair_ready_out, pair_valid_out, pair_ready_in, stage_six_serial_out;
  fss_pkg::fss_dir_t dir_in;
  fss_pkg::fss_pair_t pair_in, pair_out, seq_pair_out, exp_pair;
  fss_pkg::fss_pair_t q[$];
  int fails = 0;
  int tests_run = 0;
  int seed = 32'hd521;
  int outs = 0;
  logic [7:0] lfsr = 8'hff;

  fss_scrambler dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .dir_in(dir_in),
    .frame_start_in(frame_start_in), .pair_in(pair_in), .pair_valid_in(pair_valid_in),
    .pair_ready_out(pair_ready_out), .pair_out(pair_out), .pair_valid_out(pair_valid_out),
    .pair_ready_in(pair_ready_in), .seq_pair_out(seq_pair_out),
    .stage_six_serial_out(stage_six_serial_out));
  fsps_sink_model sink (.clk_in(clk_in), .stall_in(stall), .ready_out(pair_ready_in));

  //////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], 1'b0} ^ (s[7] ? 8'h1d : 8'h00);
  endfunction

  // Valid stays high between beats; callers let an edge pass after
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      pair_in <= 2'($random(seed));
      pair_valid_in <= 1'b1;
      do @(posedge clk_in); while (pair_ready_out !== 1'b1);
      q.push_back(pair_in);
    end
    pair_valid_in <= 1'b0;
  endtask

  task automatic frame(input fss_pkg::fss_dir_t d);
    @(posedge clk_in);
    dir_in <= d;
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge clk_in);
    check(q.size(), 8'h00);
  endtask

  //////////////////////////////////////////////////////////////
  // Old output sampled before the edge; reload after the compare
  always @(posedge clk_in) begin
    if (reset_n_in && pair_valid_out === 1'b1) begin
      exp_pair = q.pop_front() ^ {lfsr[5], lfsr[4]};
      check(pair_out, exp_pair);
      lfsr = step(step(lfsr));
      check(seq_pair_out, {lfsr[5], lfsr[4]});
      check(stage_six_serial_out, lfsr[5]);
      outs++;
    end
    if (frame_start_in === 1'b1) lfsr = 8'hff;
  end

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end

  initial begin
    reset_n_in = 1'b0;
    frame_start_in = 1'b0;
    pair_valid_in = 1'b0;
    pair_in = 2'h0;
    stall = 1'b0;
    dir_in = fss_pkg::FSS_DIR_TX;
    repeat (10) @(posedge clk_in);
    check({pair_ready_out, pair_valid_out, stage_six_serial_out, seq_pair_out, pair_out},
      8'h1c);
    reset_n_in <= 1'b1;
    frame(fss_pkg::FSS_DIR_TX);
    stall <= 1'b1;
    push(16);
    repeat (3) @(posedge clk_in);
    check(pair_ready_out, 8'h00);
    stall <= 1'b0;
    push(284);
    drain();
    frame(fss_pkg::FSS_DIR_RX);
    push(40);
    drain();
    check(outs, 16'h0154);
    tally_and_finish();
  end
endmodule
